// >>> rtl/oscdiv_top.sv
`default_nettype none

module oscdiv_top #(
    parameter int SWITCH_CYCLES = 16,
    parameter logic [2:0] POR_SOURCE = 3'h0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic irq_pending,
    output logic secondary_osc_on,
    output logic [2:0] clock_source_sel,
    output logic switch_busy,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic [2:0] internal_rc_postscale,
    output logic [1:0] pll_output_divider,
    output logic [4:0] pll_input_divider
);

    if (SWITCH_CYCLES < 1 || SWITCH_CYCLES > 255) begin : g_chk
        $error("SWITCH_CYCLES must lie in 1..255");
    end

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    function automatic logic hits(input logic [31:0] a, input logic [3:0] off);
        return (a[31:4] == 28'h0000000) && (a[3:0] == off);
    endfunction

    logic acc;
    logic wr;
    logic mapped;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign mapped = hits(paddr, oscdiv_pkg::ADDR_OSC) || hits(paddr, oscdiv_pkg::ADDR_DIV)
                    || hits(paddr, oscdiv_pkg::ADDR_KEY) || hits(paddr, oscdiv_pkg::ADDR_STAT);

    logic osc_wr;
    logic div_wr;
    logic key_wr;
    assign osc_wr = wr && hits(paddr, oscdiv_pkg::ADDR_OSC);
    assign div_wr = wr && hits(paddr, oscdiv_pkg::ADDR_DIV);
    assign key_wr = wr && hits(paddr, oscdiv_pkg::ADDR_KEY);

    // ****************************************************************
    // Unlock sequence
    // ****************************************************************
    oscdiv_pkg::oscdiv_lock_t lock_q;
    oscdiv_pkg::oscdiv_lock_t lock_d;
    logic osc_take;
    assign osc_take = osc_wr && (lock_q == oscdiv_pkg::OSCDIV_OPEN);

    // Any write other than the second key breaks the sequence, so stray traffic
    // between the keys cannot leave the register open.
    always_comb begin
        lock_d = lock_q;
        if (wr) begin
            case (lock_q)
                oscdiv_pkg::OSCDIV_LOCKED: begin
                    if (key_wr && pwdata[15:0] == oscdiv_pkg::UNLOCK_KEY1) begin
                        lock_d = oscdiv_pkg::OSCDIV_ARMED;
                    end
                end
                oscdiv_pkg::OSCDIV_ARMED: begin
                    if (key_wr && pwdata[15:0] == oscdiv_pkg::UNLOCK_KEY2) begin
                        lock_d = oscdiv_pkg::OSCDIV_OPEN;
                    end else begin
                        lock_d = oscdiv_pkg::OSCDIV_LOCKED;
                    end
                end
                oscdiv_pkg::OSCDIV_OPEN: begin
                    lock_d = oscdiv_pkg::OSCDIV_LOCKED;
                end
                default: begin
                    lock_d = oscdiv_pkg::OSCDIV_LOCKED;
                end
            endcase
        end
    end

    // ****************************************************************
    // Oscillator control and switch sequencing
    // ****************************************************************
    logic [15:0] osc_q;
    logic [15:0] osc_d;
    logic [7:0] sw_cnt_q;
    logic [7:0] sw_cnt_d;
    logic [2:0] src_q;
    logic [2:0] src_d;
    logic sw_done;
    assign sw_done = osc_q[oscdiv_pkg::OSC_REQ_BIT] && (sw_cnt_q == 8'(SWITCH_CYCLES - 1));

    always_comb begin
        osc_d = osc_q;
        sw_cnt_d = sw_cnt_q;
        src_d = src_q;
        if (osc_q[oscdiv_pkg::OSC_REQ_BIT]) begin
            sw_cnt_d = sw_cnt_q + 8'h01;
        end
        if (sw_done) begin
            osc_d[oscdiv_pkg::OSC_REQ_BIT] = 1'b0;
            src_d = osc_q[oscdiv_pkg::NEW_SRC_LSB +: oscdiv_pkg::SRC_W];
            sw_cnt_d = 8'h00;
        end
        if (osc_take) begin
            // Software can only raise the request; a written zero does not cancel it.
            osc_d[oscdiv_pkg::OSC_EN_BIT] = pwdata[oscdiv_pkg::OSC_EN_BIT];
            osc_d[oscdiv_pkg::NEW_SRC_LSB +: oscdiv_pkg::SRC_W] =
                pwdata[oscdiv_pkg::NEW_SRC_LSB +: oscdiv_pkg::SRC_W];
            if (pwdata[oscdiv_pkg::OSC_REQ_BIT]) begin
                osc_d[oscdiv_pkg::OSC_REQ_BIT] = 1'b1;
                sw_cnt_d = 8'h00;
            end
        end
    end

    // ****************************************************************
    // Clock divisor and recovery on interrupt
    // ****************************************************************
    logic [15:0] div_q;
    logic [15:0] div_d;
    logic recover;
    assign recover = irq_pending && div_q[oscdiv_pkg::RECOVER_BIT];

    always_comb begin
        div_d = div_q;
        if (div_wr) begin
            div_d = pwdata[15:0] & oscdiv_pkg::DIV_WMASK;
        end
        if (recover) begin
            // The interrupt beats a same-cycle write so the recovery is never missed.
            div_d[oscdiv_pkg::REDUCE_EN_BIT] = 1'b0;
        end
    end

    // ****************************************************************
    // Processor clock reduction
    // ****************************************************************
    logic [oscdiv_pkg::DOZE_CNT_W-1:0] doze_cnt_q;
    logic [oscdiv_pkg::DOZE_CNT_W-1:0] doze_cnt_d;
    logic [oscdiv_pkg::DOZE_CNT_W-1:0] doze_mask;
    logic reduce_on;
    assign reduce_on = div_q[oscdiv_pkg::REDUCE_EN_BIT];
    assign doze_mask = oscdiv_pkg::DOZE_CNT_W'((8'h01 << div_q[oscdiv_pkg::DOZE_LSB +:
                       oscdiv_pkg::DOZE_W]) - 8'h01);

    always_comb begin
        doze_cnt_d = (doze_cnt_q + 7'h01) & doze_mask;
        if (!reduce_on || div_wr) begin
            doze_cnt_d = 7'h00;
        end
    end

    assign cpu_clk_en = !reduce_on || (doze_cnt_q == 7'h00);
    assign periph_clk_en = 1'b1;

    // ****************************************************************
    // State registers
    // ****************************************************************
    // The bus reset is the power-on reset; no other reset cause reaches here.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_q <= oscdiv_pkg::OSCDIV_LOCKED;
            osc_q <= {5'h00, POR_SOURCE, 8'h00};
            div_q <= oscdiv_pkg::DIV_RESET;
            src_q <= POR_SOURCE;
            sw_cnt_q <= 8'h00;
            doze_cnt_q <= 7'h00;
        end else begin
            lock_q <= lock_d;
            osc_q <= osc_d;
            div_q <= div_d;
            src_q <= src_d;
            sw_cnt_q <= sw_cnt_d;
            doze_cnt_q <= doze_cnt_d;
        end
    end

    // ****************************************************************
    // Outputs and read path
    // ****************************************************************
    assign secondary_osc_on = osc_q[oscdiv_pkg::OSC_EN_BIT];
    assign clock_source_sel = src_q;
    assign switch_busy = osc_q[oscdiv_pkg::OSC_REQ_BIT];
    assign internal_rc_postscale = div_q[oscdiv_pkg::RC_POST_LSB +: oscdiv_pkg::RC_POST_W];
    assign pll_output_divider = div_q[oscdiv_pkg::POST_LSB +: oscdiv_pkg::POST_W];
    assign pll_input_divider = div_q[oscdiv_pkg::PRE_LSB +: oscdiv_pkg::PRE_W];
    assign pready = 1'b1;
    assign pslverr = acc && (!mapped || (osc_wr && !osc_take));

    always_comb begin
        prdata = 32'h00000000;
        if (acc && !pwrite) begin
            if (hits(paddr, oscdiv_pkg::ADDR_OSC)) begin
                prdata[15:0] = osc_q & oscdiv_pkg::OSC_WMASK;
            end else if (hits(paddr, oscdiv_pkg::ADDR_DIV)) begin
                prdata[15:0] = div_q;
            end else if (hits(paddr, oscdiv_pkg::ADDR_STAT)) begin
                prdata[oscdiv_pkg::STAT_BUSY_BIT] = switch_busy;
                prdata[oscdiv_pkg::STAT_OPEN_BIT] = lock_q == oscdiv_pkg::OSCDIV_OPEN;
                prdata[oscdiv_pkg::STAT_SRC_LSB +: oscdiv_pkg::SRC_W] = src_q;
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    logic [7:0] gap_q;
    logic gap_ok_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q <= 8'h00;
            gap_ok_q <= 1'b0;
        end else begin
            gap_q <= cpu_clk_en ? 8'h00 : gap_q + 8'h01;
            gap_ok_q <= reduce_on && !div_wr && (gap_ok_q || cpu_clk_en);
        end
    end

    a_sec_osc_follow: assert property (@(posedge pclk) disable iff (!presetn)
        osc_take |=> secondary_osc_on == $past(pwdata[oscdiv_pkg::OSC_EN_BIT]))
        else $error("secondary oscillator does not follow its enable bit");

    a_switch_clears: assert property (@(posedge pclk) disable iff (!presetn)
        sw_done && !(osc_take && pwdata[oscdiv_pkg::OSC_REQ_BIT]) |=> !switch_busy
            && clock_source_sel == $past(osc_q[oscdiv_pkg::NEW_SRC_LSB +: oscdiv_pkg::SRC_W]))
        else $error("switch request not cleared at completion");

    a_locked_write_drop: assert property (@(posedge pclk) disable iff (!presetn)
        osc_wr && lock_q != oscdiv_pkg::OSCDIV_OPEN
            |=> $stable(osc_q[oscdiv_pkg::NEW_SRC_LSB +: oscdiv_pkg::SRC_W])
            && $stable(secondary_osc_on))
        else $error("oscillator control written without unlock");

    a_unlock_single: assert property (@(posedge pclk) disable iff (!presetn)
        osc_take |=> lock_q == oscdiv_pkg::OSCDIV_LOCKED)
        else $error("unlock survived an accepted write");

    a_irq_recovers: assert property (@(posedge pclk) disable iff (!presetn)
        recover |=> !reduce_on ##0 cpu_clk_en)
        else $error("interrupt did not restore unity clock ratio");

    a_no_recover_keeps: assert property (@(posedge pclk) disable iff (!presetn)
        irq_pending && !div_q[oscdiv_pkg::RECOVER_BIT] && !div_wr |=> $stable(div_q))
        else $error("interrupt changed clock reduction without recovery");

    a_doze_ratio: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_clk_en && gap_ok_q && reduce_on |-> 8'(gap_q + 8'h01) ==
            (8'h01 << div_q[oscdiv_pkg::DOZE_LSB +: oscdiv_pkg::DOZE_W])
            && periph_clk_en)
        else $error("processor clock ratio wrong under reduction");

endmodule

`default_nettype wire

// >>> rtl/oscdiv_pkg.sv
`default_nettype none

package oscdiv_pkg;

    // ****************************************************************
    // Register map and fields
    // ****************************************************************
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_OSC = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_DIV = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_KEY = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 4'hC;

    localparam int OSC_REQ_BIT = 0;
    localparam int OSC_EN_BIT = 1;
    localparam int NEW_SRC_LSB = 8;
    localparam int SRC_W = 3;
    localparam logic [15:0] OSC_WMASK = 16'h0703;

    localparam int PRE_LSB = 0;
    localparam int PRE_W = 5;
    localparam int POST_LSB = 6;
    localparam int POST_W = 2;
    localparam int RC_POST_LSB = 8;
    localparam int RC_POST_W = 3;
    localparam int REDUCE_EN_BIT = 11;
    localparam int DOZE_LSB = 12;
    localparam int DOZE_W = 3;
    localparam int RECOVER_BIT = 15;
    localparam logic [15:0] DIV_RESET = 16'h3040;
    localparam logic [15:0] DIV_WMASK = 16'hFFDF;

    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_OPEN_BIT = 1;
    localparam int STAT_SRC_LSB = 2;

    localparam logic [15:0] UNLOCK_KEY1 = 16'h00A5;
    localparam logic [15:0] UNLOCK_KEY2 = 16'h005A;

    localparam int DOZE_CNT_W = 7;

    typedef enum logic [2:0] {
        OSCDIV_LOCKED = 3'b001,
        OSCDIV_ARMED = 3'b010,
        OSCDIV_OPEN = 3'b100
    } oscdiv_lock_t;

endpackage

`default_nettype wire

// >>> verif/tb_top.sv
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // Switch length given to the design; the completion check counts exactly this many cycles.
    localparam int SW_CYC = 2;
    localparam logic [2:0] FAST_INTERNAL_RC = 3'h0;
    localparam logic [2:0] FAST_INTERNAL_RC_WITH_PLL = 3'h1;
    localparam logic [2:0] PRIMARY_WITH_PLL = 3'h3;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic irq_pending = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic secondary_osc_on;
    logic [2:0] clock_source_sel;
    logic switch_busy;
    logic cpu_clk_en;
    logic periph_clk_en;
    logic [2:0] internal_rc_postscale;
    logic [1:0] pll_output_divider;
    logic [4:0] pll_input_divider;
    int error_cnt = 0;
    int tests_run = 0;
    int lk = 0;
    integer seed = 32'h846142A4;
    logic [15:0] osc_m = 16'h0;
    logic [15:0] div_m = 16'h3040;
    logic [2:0] src_m = 3'h0;
    logic [31:0] rd;
    logic err;

    always #25 pclk = ~pclk;

    oscdiv_top #(.SWITCH_CYCLES(SW_CYC), .POR_SOURCE(3'h0)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_pending(irq_pending), .secondary_osc_on(secondary_osc_on),
        .clock_source_sel(clock_source_sel), .switch_busy(switch_busy),
        .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
        .internal_rc_postscale(internal_rc_postscale),
        .pll_output_divider(pll_output_divider), .pll_input_divider(pll_input_divider)
    );

    // ************************************************************
    // Bus and comparison tasks
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Each transfer begins one edge after the last release so no signal is driven twice.
    task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        logic e;
        e = 1'b0;
        case (a)
            32'h0: if (lk == 2) osc_m = (d & 16'h0703) | (osc_m & 16'h0001); else e = 1'b1;
            32'h4: div_m = d & oscdiv_pkg::DIV_WMASK;
            32'h8: e = 1'b0;
            default: e = 1'b1;
        endcase
        lk = (lk == 0 && a == 32'h8 && d == 16'h00A5) ? 1 :
             (lk == 1 && a == 32'h8 && d == 16'h005A) ? 2 : 0;
        apb(a, 1'b1, {16'h0, d});
        chk({31'h0, err}, {31'h0, e});
    endtask

    task automatic rdc(input logic [31:0] a);
        logic [31:0] x;
        case (a)
            32'h0: x = {16'h0, osc_m};
            32'h4: x = {16'h0, div_m};
            32'hC: x = {27'h0, src_m, lk == 2, osc_m[0]};
            default: x = 32'h0;
        endcase
        apb(a, 1'b0, 32'h0);
        chk(rd, x);
        chk({31'h0, err}, {31'h0, a > 32'hC});
    endtask

    task automatic chk_outs;
        chk({31'h0, secondary_osc_on}, {31'h0, osc_m[1]});
        chk({31'h0, switch_busy}, {31'h0, osc_m[0]});
        chk({29'h0, clock_source_sel}, {29'h0, src_m});
        chk({29'h0, internal_rc_postscale}, {29'h0, div_m[10:8]});
        chk({30'h0, pll_output_divider}, {30'h0, div_m[7:6]});
        chk({27'h0, pll_input_divider}, {27'h0, div_m[4:0]});
    endtask

    task automatic clk_count(input int exp);
        int c;
        int p;
        c = 0;
        p = 0;
        repeat (128) begin
            @(negedge pclk);
            c += (cpu_clk_en === 1'b1);
            p += (periph_clk_en === 1'b1);
        end
        chk(c, exp);
        chk(p, 128);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        int n;
        logic [2:0] ns;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk_outs();
        for (int a = 0; a <= 16; a += 4) rdc(a);
        wr(0, 16'h0002);
        wr(8, 16'h00A5);
        wr(8, 16'h005A);
        rdc(12);
        wr(0, 16'h0002);
        @(negedge pclk);
        chk_outs();
        for (int i = 0; i < 3; i++) begin
            ns = 3'($random(seed));
            // A direct hop between the two PLL modes is illegal, so such a hop is replaced by a switch to plain RC.
            if ((src_m == FAST_INTERNAL_RC_WITH_PLL && ns == PRIMARY_WITH_PLL) ||
                (src_m == PRIMARY_WITH_PLL && ns == FAST_INTERNAL_RC_WITH_PLL)) begin
                ns = FAST_INTERNAL_RC;
            end
            wr(8, 16'h00A5);
            wr(8, 16'h005A);
            wr(0, {5'h0, ns, 8'h03});
            @(negedge pclk);
            chk({31'h0, switch_busy}, 32'h1);
            n = 0;
            while (switch_busy !== 1'b0 && n < 10) begin
                @(negedge pclk);
                n++;
            end
            chk(n, SW_CYC);
            osc_m[0] = 1'b0;
            src_m = ns;
            chk_outs();
            rdc(12);
            rdc(0);
        end
        repeat (8) begin
            wr(4, 16'($random(seed)));
            @(negedge pclk);
            chk_outs();
            rdc(4);
        end
        for (int d = 0; d <= 8; d++) begin
            wr(4, d < 8 ? 16'h0800 | 16'(d << 12) : 16'h7000);
            clk_count(d < 8 ? 128 >> d : 128);
        end
        for (int r = 0; r < 2; r++) begin
            wr(4, 16'h2800 | 16'(r << 15));
            @(posedge pclk);
            irq_pending <= 1'b1;
            @(posedge pclk);
            irq_pending <= 1'b0;
            if (r == 1) div_m[11] = 1'b0;
            rdc(4);
            clk_count(r == 1 ? 128 : 32);
        end
        // An intervening write must relock, so the next control write is refused.
        wr(8, 16'h00A5);
        wr(4, 16'h0141);
        wr(8, 16'h005A);
        wr(0, 16'h0000);
        @(negedge pclk);
        chk_outs();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        osc_m = 16'h0;
        div_m = 16'h3040;
        src_m = 3'h0;
        lk = 0;
        chk_outs();
        presetn <= 1'b1;
        rdc(4);
        rdc(0);
        end_sim();
    end
endmodule

`default_nettype wire
